// ===== common/pfc_pkg.sv
// Shared constants and carrier types for the pad function configuration block.
// Assumes a 32-bit Avalon-MM register slave with byte addresses and 12 port pins.
`default_nettype none

package pfc_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NPINS  = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] CFG_BASE_OFS  = 8'h00;  // Pin n config at CFG_BASE_OFS + 4*n
  localparam logic [7:0] DIR_OFS       = 8'h30;  // Port direction, bit n for pin n
  localparam logic [7:0] PIN_STATE_OFS = 8'h34;  // Synchronised pin levels, read only
  localparam logic [3:0] BE_FULL       = 4'hF;

  // ==========================================================================
  // Pin classes
  // ==========================================================================
  localparam logic [NPINS-1:0] BUS_PAD_MASK = 12'h030;  // bus_pad_a, bus_pad_b
  localparam logic [NPINS-1:0] HD_PAD_MASK  = 12'hC88;  // high_drive_pad_a..d

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [2:0] FUNCTION_SELECT_GPIO = 3'h0;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_PD   = 2'h1;
  localparam logic [1:0] MODE_PU   = 2'h2;
  localparam logic [1:0] MODE_RPT  = 2'h3;

  // Pin configuration word, LSB last
  typedef struct packed {
    logic [14:0] rsvd;               // Reads as zero
    logic [3:0]  sink_current_high;  // Sink level while driving high
    logic [3:0]  sink_current_low;   // Sink level while driving low
    logic        analog_sink;        // 1: analog current sink mode
    logic        bus_plain_od;       // 1: plain open-drain, no glitch filter
    logic        hyst_en;            // Input hysteresis
    logic        input_mode;         // Input mode select
    logic [1:0]  mode;               // Resistor mode
    logic [2:0]  function_select;    // 0: GPIO, else peripheral
  } pfc_cfg_t;

  localparam logic [31:0] CFG_WMASK = 32'h0001FFFF;
  localparam pfc_cfg_t    CFG_RESET = '0;
  localparam logic [NPINS-1:0] DIR_RESET = 12'h000;

  // Electrical controls of one pad
  typedef struct packed {
    logic       out;
    logic       oe;
    logic       pu_en;
    logic       pd_en;
    logic       hyst_en;
    logic       input_mode;
    logic       filt_en;
    logic       analog;
    logic [3:0] sink_code;
  } pfc_pad_t;

endpackage

`default_nettype wire

// ===== hw/pfc_top.sv
// Pad function configuration: per-pin function, direction source, resistor,
// bus-pad and high-drive controls behind an Avalon-MM register slave.
// Assumes pad_in is asynchronous; GPIO and peripheral signals share clk.
//
// How it works
// - Function code zero selects GPIO, else peripheral.
// - GPIO pins take direction from port_direction.
// - Peripheral pins take direction from the peripheral.
// - Resistor mode: pull-up, pull-down, none, repeater.
// - Reset leaves every pin without pull resistors.
// - Repeater pulls toward the pin's current level.
// - Repeater retention dropped during deep power-down.
// - Bus pads under a peripheral: filtered open-drain or plain open-drain.
// - High-drive pads: digital or analog sink current.
// - Each pin holds input mode and hysteresis.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pfc_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Avalon-MM slave
  input  wire logic [pfc_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [pfc_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [pfc_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // GPIO port and peripherals
  input  wire logic [pfc_pkg::NPINS-1:0]     gpio_out,
  output logic      [pfc_pkg::NPINS-1:0]     gpio_in,
  input  wire logic [pfc_pkg::NPINS-1:0]     periph_out,
  input  wire logic [pfc_pkg::NPINS-1:0]     periph_oe,
  output logic      [pfc_pkg::NPINS-1:0]     periph_in,
  // Power state from the power manager
  input  wire logic                          deep_pd,
  // Pads
  input  wire logic [pfc_pkg::NPINS-1:0]     pad_in,
  output var pfc_pkg::pfc_pad_t [pfc_pkg::NPINS-1:0] pad_ctl
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic pfc_is_gpio(input logic [2:0] fs);
    pfc_is_gpio = (fs == pfc_pkg::FUNCTION_SELECT_GPIO);
  endfunction

  function automatic logic pfc_cfg_hit(input logic [pfc_pkg::ADDR_W-1:0] a, input int n);
    pfc_cfg_hit = (a[7:2] == 6'(pfc_pkg::CFG_BASE_OFS[7:2] + 6'(n)));
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  pfc_pkg::pfc_cfg_t [pfc_pkg::NPINS-1:0] cfg_q;
  logic [pfc_pkg::NPINS-1:0]              port_direction_q;
  logic [pfc_pkg::NPINS-1:0]              sync1_q;
  logic [pfc_pkg::NPINS-1:0]              sync2_q;
  logic [pfc_pkg::NPINS-1:0]              prev_q;
  logic [pfc_pkg::NPINS-1:0]              filt_q;
  logic [pfc_pkg::DATA_W-1:0]             rdata_d;
  pfc_pkg::pfc_pad_t [pfc_pkg::NPINS-1:0] pad_d;
  logic [pfc_pkg::NPINS-1:0]              gpio_in_d;
  logic [pfc_pkg::NPINS-1:0]              periph_in_d;
  logic                                   wr_fire;
  logic                                   full_word;
  pfc_pkg::pfc_cfg_t                      wdata_cfg;

  // Transfer completes at the edge where waitrequest is already low
  assign full_word = (avs_byteenable == pfc_pkg::BE_FULL);
  assign wr_fire   = avs_write && !avs_waitrequest && full_word;
  // Write data seen as a config word, so checks name fields, not bit positions
  assign wdata_cfg = pfc_pkg::pfc_cfg_t'(avs_writedata);

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // One wait state on every access keeps readdata a plain register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Read mux, captured during the wait cycle; unmapped reads return zero
  always_comb begin
    rdata_d = '0;
    for (int n = 0; n < pfc_pkg::NPINS; n++) begin
      if (pfc_cfg_hit(avs_address, n)) begin
        rdata_d = cfg_q[n];
      end
    end
    if (avs_address[7:2] == pfc_pkg::DIR_OFS[7:2]) begin
      rdata_d = 32'(port_direction_q);
    end
    if (avs_address[7:2] == pfc_pkg::PIN_STATE_OFS[7:2]) begin
      rdata_d = 32'(sync2_q);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Partial-word writes are dropped: the register file only supports words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int n = 0; n < pfc_pkg::NPINS; n++) begin
        cfg_q[n] <= pfc_pkg::CFG_RESET;
      end
    end else if (wr_fire) begin
      for (int n = 0; n < pfc_pkg::NPINS; n++) begin
        if (pfc_cfg_hit(avs_address, n)) begin
          cfg_q[n] <= pfc_pkg::pfc_cfg_t'(avs_writedata & pfc_pkg::CFG_WMASK);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_direction_q <= pfc_pkg::DIR_RESET;
    end else if (wr_fire && avs_address[7:2] == pfc_pkg::DIR_OFS[7:2]) begin
      port_direction_q <= avs_writedata[pfc_pkg::NPINS-1:0];
    end
  end

  // ==========================================================================
  // Pad input synchroniser and bus-pad glitch filter
  // ==========================================================================
  // Filter passes a level only after two equal samples; costs two cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
      filt_q  <= '0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      filt_q  <= (sync2_q & prev_q) | (filt_q & (sync2_q | prev_q));
    end
  end

  // ==========================================================================
  // Per-pin pad control
  // ==========================================================================
  for (genvar i = 0; i < pfc_pkg::NPINS; i++) begin : g_pin
    logic gpio_sel;
    logic drive;
    logic is_bus;
    logic is_hd;
    logic filt_on;

    assign gpio_sel = pfc_is_gpio(cfg_q[i].function_select);
    assign is_bus   = pfc_pkg::BUS_PAD_MASK[i];
    assign is_hd    = pfc_pkg::HD_PAD_MASK[i];
    assign drive    = gpio_sel ? gpio_out[i] : periph_out[i];
    assign filt_on  = is_bus && !gpio_sel && !cfg_q[i].bus_plain_od;

    always_comb begin
      pad_d[i]            = '0;
      pad_d[i].hyst_en    = cfg_q[i].hyst_en;
      pad_d[i].input_mode = cfg_q[i].input_mode;
      if (gpio_sel) begin
        pad_d[i].oe  = port_direction_q[i];
        pad_d[i].out = drive;
      end else if (is_bus) begin
        // Both bus modes drive low only, the line floats high otherwise
        pad_d[i].oe      = periph_oe[i] && !periph_out[i];
        pad_d[i].out     = 1'b0;
        pad_d[i].filt_en = filt_on;
      end else begin
        pad_d[i].oe  = periph_oe[i];
        pad_d[i].out = drive;
      end
      // Analog sink picks the current level from the driven value
      if (is_hd && cfg_q[i].analog_sink) begin
        pad_d[i].analog    = 1'b1;
        pad_d[i].sink_code = drive ? cfg_q[i].sink_current_high
                                   : cfg_q[i].sink_current_low;
      end
      case (cfg_q[i].mode)
        pfc_pkg::MODE_PU: begin
          pad_d[i].pu_en = 1'b1;
        end
        pfc_pkg::MODE_PD: begin
          pad_d[i].pd_en = 1'b1;
        end
        pfc_pkg::MODE_RPT: begin
          // Keeper cannot be trusted once the core is unpowered
          pad_d[i].pu_en = !deep_pd && sync2_q[i];
          pad_d[i].pd_en = !deep_pd && !sync2_q[i];
        end
        default: begin
          pad_d[i].pu_en = 1'b0;
        end
      endcase
    end

    assign gpio_in_d[i]   = sync2_q[i];
    assign periph_in_d[i] = filt_on ? filt_q[i] : sync2_q[i];

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_gpio_dir;
      @(posedge clk) disable iff (reset)
      pfc_is_gpio(cfg_q[i].function_select) |=> pad_ctl[i].oe == $past(port_direction_q[i]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("GPIO pin ignores direction");

    property p_function_select_route;
      @(posedge clk) disable iff (reset)
      (!pfc_is_gpio(cfg_q[i].function_select) && !is_bus)
        |=> pad_ctl[i].oe == $past(periph_oe[i]) && pad_ctl[i].out == $past(periph_out[i]);
    endproperty
    a_function_select_route: assert property (p_function_select_route) else $error("Peripheral not routed");

    property p_periph_dir;
      @(posedge clk) disable iff (reset)
      (!pfc_is_gpio(cfg_q[i].function_select) && !is_bus && $changed(port_direction_q[i]))
        |=> pad_ctl[i].oe == $past(periph_oe[i]);
    endproperty
    a_periph_dir: assert property (p_periph_dir) else $error("Direction leaks to peripheral");

    property p_no_pull;
      @(posedge clk) disable iff (reset)
      cfg_q[i].mode == pfc_pkg::MODE_NONE |=> !pad_ctl[i].pu_en && !pad_ctl[i].pd_en;
    endproperty
    a_no_pull: assert property (p_no_pull) else $error("Pull active in none mode");

    property p_reset_pull;
      @(posedge clk) $fell(reset) |-> !pad_ctl[i].pu_en && !pad_ctl[i].pd_en;
    endproperty
    a_reset_pull: assert property (p_reset_pull) else $error("Pull active after reset");

    property p_repeater;
      @(posedge clk) disable iff (reset)
      (cfg_q[i].mode == pfc_pkg::MODE_RPT && !deep_pd)
        |=> pad_ctl[i].pu_en == $past(sync2_q[i]) && pad_ctl[i].pd_en == !$past(sync2_q[i]);
    endproperty
    a_repeater: assert property (p_repeater) else $error("Repeater level wrong");

    property p_deep_pd;
      @(posedge clk) disable iff (reset)
      (cfg_q[i].mode == pfc_pkg::MODE_RPT && deep_pd) |=> !pad_ctl[i].pu_en && !pad_ctl[i].pd_en;
    endproperty
    a_deep_pd: assert property (p_deep_pd) else $error("Keeper on in deep power-down");

    property p_bus_od;
      @(posedge clk) disable iff (reset)
      (is_bus && !pfc_is_gpio(cfg_q[i].function_select))
        |=> !pad_ctl[i].out && pad_ctl[i].filt_en == !$past(cfg_q[i].bus_plain_od);
    endproperty
    a_bus_od: assert property (p_bus_od) else $error("Bus pad not open-drain");

    property p_sink;
      @(posedge clk) disable iff (reset)
      (is_hd && cfg_q[i].analog_sink && drive)
        |=> pad_ctl[i].analog && pad_ctl[i].sink_code == $past(cfg_q[i].sink_current_high);
    endproperty
    a_sink: assert property (p_sink) else $error("Sink current not high level");

    property p_hyst;
      @(posedge clk) disable iff (reset)
      1'b1 |=> pad_ctl[i].hyst_en == $past(cfg_q[i].hyst_en)
               && pad_ctl[i].input_mode == $past(cfg_q[i].input_mode);
    endproperty
    a_hyst: assert property (p_hyst) else $error("Input settings not applied");

    property p_write_effect;
      @(posedge clk) disable iff (reset)
      (wr_fire && pfc_cfg_hit(avs_address, i))
        |=> ##1 pad_ctl[i].hyst_en == $past(wdata_cfg.hyst_en, 2);
    endproperty
    a_write_effect: assert property (p_write_effect) else $error("Write not on pad");

    property p_sink_low;
      @(posedge clk) disable iff (reset)
      (is_hd && cfg_q[i].analog_sink && !drive)
        |=> pad_ctl[i].analog && pad_ctl[i].sink_code == $past(cfg_q[i].sink_current_low);
    endproperty
    a_sink_low: assert property (p_sink_low) else $error("Sink current not low level");

    property p_plain_in;
      @(posedge clk) disable iff (reset)
      (is_bus && !pfc_is_gpio(cfg_q[i].function_select) && cfg_q[i].bus_plain_od)
        |=> periph_in[i] == $past(sync2_q[i]);
    endproperty
    a_plain_in: assert property (p_plain_in) else $error("Plain bus input filtered");

    property p_part_drop;
      @(posedge clk) disable iff (reset)
      (avs_write && !avs_waitrequest && !full_word) |=> $stable(cfg_q[i]);
    endproperty
    a_part_drop: assert property (p_part_drop) else $error("Partial write stored");
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pad_ctl   <= '0;
      gpio_in   <= '0;
      periph_in <= '0;
    end else begin
      pad_ctl   <= pad_d;
      gpio_in   <= gpio_in_d;
      periph_in <= periph_in_d;
    end
  end

  // Bus answers one cycle after the request is seen
  property p_wait;
    @(posedge clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("Waitrequest not released");

endmodule

`default_nettype wire

// ===== dv/tb_pad_function_config.sv
// Self-checking bench for the pad function configuration block.
// Assumes the Avalon-MM slave answers with one waitrequest-low cycle and that
// pad controls follow their causes one clock edge later.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module tb_pad_function_config;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                                  clk;
  logic                                  reset;
  logic [7:0]                            avs_address;
  logic                                  avs_read;
  logic                                  avs_write;
  logic [31:0]                           avs_writedata;
  logic [3:0]                            avs_byteenable;
  logic [31:0]                           avs_readdata;
  logic                                  avs_waitrequest;
  logic [11:0]                           gpio_out;
  logic [11:0]                           gpio_in;
  logic [11:0]                           periph_out;
  logic [11:0]                           periph_oe;
  logic [11:0]                           periph_in;
  logic                                  deep_pd;
  logic [11:0]                           pad_in;
  pfc_pkg::pfc_pad_t [pfc_pkg::NPINS-1:0] pad_ctl;
  int                                    err_count;
  int                                    cmp_count;
  logic [1:0]                            ex;

  pfc_top pfc_top_i (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpio_out(gpio_out),
    .gpio_in(gpio_in), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .deep_pd(deep_pd), .pad_in(pad_in), .pad_ctl(pad_ctl)
  );

  // ==========================================================================
  // Clock and hang guard
  // ==========================================================================
  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A stuck slave must not hang the run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("unexpected run timeout");
    test_done();
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Verdict and end of run
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One Avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      err_count++;
      $display("unexpected waitrequest timeout");
      test_done();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(nm, exp, q)
  endtask

  // Waits long enough for registered pad controls to follow their cause
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    reset = 1'b1; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; gpio_out = 12'h000;
    periph_out = 12'h000; periph_oe = 12'h000; deep_pd = 1'b0; pad_in = 12'h000;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Defaults after reset: GPIO inputs, no pulls
    settle(1);
    for (int i = 0; i < 12; i++) begin
      `CHK("pulls", 2'b00, {pad_ctl[i].pu_en, pad_ctl[i].pd_en})
      `CHK("oe", 1'b0, pad_ctl[i].oe)
      rd_chk(8'(4 * i), 32'h0, "cfg reset");
    end
    rd_chk(pfc_pkg::DIR_OFS, 32'h0, "dir reset");
    $display("test reset_defaults done");

    // Write timing, independent input settings, storage and refused writes
    wr(8'h00, 32'h0000_0060);
    settle(1);
    `CHK("hyst early", 1'b0, pad_ctl[0].hyst_en)
    settle(1);
    `CHK("hyst", 1'b1, pad_ctl[0].hyst_en)
    `CHK("input mode", 1'b1, pad_ctl[0].input_mode)
    wr(8'h04, 32'h0000_0020);
    settle(2);
    `CHK("hyst off", 2'b01, {pad_ctl[1].hyst_en, pad_ctl[1].input_mode})
    wr(8'h08, 32'hFFFF_FFFF);
    rd_chk(8'h08, pfc_pkg::CFG_WMASK, "cfg readback");
    @(posedge clk) avs_byteenable <= 4'h3;
    wr(8'h08, 32'h0000_0000);
    @(posedge clk) avs_byteenable <= 4'hF;
    rd_chk(8'h08, pfc_pkg::CFG_WMASK, "partial write");
    wr(8'h38, 32'hFFFF_FFFF);
    rd_chk(8'h38, 32'h0, "unmapped");
    $display("test storage done");

    // Every function code on pin 2: only code zero follows the GPIO port
    wr(pfc_pkg::DIR_OFS, 32'h0000_0004);
    @(posedge clk) gpio_out <= 12'h004;
    for (int c = 0; c < 8; c++) begin
      wr(8'h08, 32'(c));
      settle(2);
      `CHK("fn oe", (c == 0), pad_ctl[2].oe)
      `CHK("fn out", (c == 0), pad_ctl[2].out)
    end
    wr(pfc_pkg::DIR_OFS, 32'h0000_0000);
    @(posedge clk) periph_oe <= 12'h004;
    periph_out <= 12'h004;
    settle(2);
    `CHK("periph drive", 2'b11, {pad_ctl[2].oe, pad_ctl[2].out})
    wr(8'h08, 32'h0000_0000);
    settle(2);
    `CHK("gpio ignores periph", 1'b0, pad_ctl[2].oe)
    $display("test function_select done");

    // Resistor modes at both pin levels on pin 6
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        @(posedge clk) pad_in <= 12'(l << 6);
        wr(8'h18, 32'(m << 3));
        settle(6);
        ex[1] = (2'(m) == pfc_pkg::MODE_PU) || (2'(m) == pfc_pkg::MODE_RPT && l == 1);
        ex[0] = (2'(m) == pfc_pkg::MODE_PD) || (2'(m) == pfc_pkg::MODE_RPT && l == 0);
        `CHK("pulls", ex, {pad_ctl[6].pu_en, pad_ctl[6].pd_en})
        `CHK("pin level", 1'(l), gpio_in[6])
      end
    end
    rd_chk(pfc_pkg::PIN_STATE_OFS, 32'h0000_0040, "pin state");
    @(posedge clk) deep_pd <= 1'b1;
    settle(2);
    `CHK("deep pd pulls", 2'b00, {pad_ctl[6].pu_en, pad_ctl[6].pd_en})
    @(posedge clk) deep_pd <= 1'b0;
    settle(2);
    `CHK("repeat back", 2'b10, {pad_ctl[6].pu_en, pad_ctl[6].pd_en})
    $display("test resistor_mode done");

    // Bus pad 4: open drain in both modes, filter only in bus mode
    wr(8'h10, 32'h0000_0001);
    @(posedge clk) periph_oe <= 12'h010;
    periph_out <= 12'h000;
    settle(2);
    `CHK("od low", 2'b10, {pad_ctl[4].oe, pad_ctl[4].out})
    `CHK("filter on", 1'b1, pad_ctl[4].filt_en)
    // One-cycle glitch must not reach the peripheral, a steady level must
    @(posedge clk) pad_in <= 12'h050;
    @(posedge clk) pad_in <= 12'h040;
    settle(6);
    `CHK("glitch", 1'b0, periph_in[4])
    @(posedge clk) pad_in <= 12'h050;
    settle(6);
    `CHK("filtered in", 1'b1, periph_in[4])
    @(posedge clk) periph_out <= 12'h010;
    settle(2);
    `CHK("od release", 1'b0, pad_ctl[4].oe)
    wr(8'h10, 32'h0000_0081);
    settle(2);
    `CHK("filter off", 2'b00, {pad_ctl[4].filt_en, pad_ctl[4].oe})
    // Without the filter a fall shows after three edges, two earlier than filtered
    @(posedge clk) pad_in <= 12'h040;
    settle(4);
    `CHK("unfiltered in", 1'b0, periph_in[4])
    $display("test bus_pad done");

    // High-drive pad 3: analog sink level follows the driven value
    wr(8'h0C, 32'h0001_4B01);
    @(posedge clk) periph_oe <= 12'h008;
    periph_out <= 12'h008;
    settle(2);
    `CHK("analog", 1'b1, pad_ctl[3].analog)
    `CHK("sink high", 4'hA, pad_ctl[3].sink_code)
    @(posedge clk) periph_out <= 12'h000;
    settle(2);
    `CHK("sink low", 4'h5, pad_ctl[3].sink_code)
    wr(8'h0C, 32'h0001_4A01);
    settle(2);
    `CHK("digital", 1'b0, pad_ctl[3].analog)
    $display("test high_drive done");
    test_done();
  end
endmodule

`default_nettype wire
